// ---- src/cdr_i2c_slave_reference_clock_in_ctrl.sv ----
// Notes on behaviour
// - Address msb one, low five bits zero
// - Address bit five follows select pin
// - First byte lsb: one reads, zero writes
// - Start is SDA fall, SCL high; eight bits
// - Bytes travel msb first
// - Matching address acknowledged on ninth pulse
// - Mismatch releases bus, waits for start
// - Second byte is starting register subaddress
// - Subaddress advances after every data byte below top
// - Stray stop forces idle; stray start restarts address phase
// - Invalid subaddress not acknowledged, goes idle
// - Reads past top repeat top register
// - Control bit zero selects lock-to-reference
// - Control bit one enables fine measurement
// - Lock rate set by ratio and range
// - Range field picks reference band, default 00
// - Ratio field n multiplies by two^n
// - Relock to reference after lost lock
module cdr_i2c_slave_reference_clock_in_ctrl
    import cdr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic addr_bit5_select_pin,
    input  wire logic lock_lost_in,
    output logic      ref_lock_mode,
    output logic      fine_measure_en,
    output logic [1:0] ref_range,
    output logic [3:0] ref_ratio,
    output logic      acquire_start,
    output logic      acquire_request
);

    i2c_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [2:0] ptr_reg;
    logic       rw_reg;
    logic       nack_reg;
    logic [7:0] reg_file [8];
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       sda_lvl;
    logic       addr_sel;
    logic       own_match;
    logic       byte_end;
    logic       wr_en;
    logic       locked;
    logic [7:0] status;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    i2c_line_sync u_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .addr_pin  (addr_bit5_select_pin),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det),
        .sda_lvl   (sda_lvl),
        .addr_sel  (addr_sel)
    );

    // Open drain: only ever pulls low
    assign sda_out   = 1'b0;
    assign own_match = (shift_reg[7:1] == {ADDR_MSB_VALUE, addr_sel, ADDR_LOW_VALUE});
    assign byte_end  = scl_fall && (bit_cnt_reg == BYTE_BITS);
    assign wr_en     = (state_reg == ST_WRITE) && byte_end && !start_det && !stop_det;
    assign status    = {6'h00, locked, acquire_request};
    assign rd_byte   = (ptr_reg == SUB_STATUS) ? status : reg_file[ptr_reg];

    // ------------------------------------------------------------
    // Serial protocol engine
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 3'h0;
            rw_reg      <= 1'b0;
            nack_reg    <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
        end else if (start_det) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_lvl};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_end) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR) begin
                            rw_reg    <= shift_reg[0];
                            sda_oe    <= own_match;
                            state_reg <= own_match ? ST_ACK_ADDR : ST_IDLE;
                        end else if (state_reg == ST_SUB) begin
                            sda_oe    <= (shift_reg < SUB_COUNT);
                            ptr_reg   <= shift_reg[2:0];
                            state_reg <= (shift_reg < SUB_COUNT) ? ST_ACK_SUB : ST_IDLE;
                        end else begin
                            ptr_reg   <= next_sub(ptr_reg);
                            sda_oe    <= 1'b1;
                            state_reg <= ST_ACK_WR;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            tx_reg    <= rd_byte;
                            sda_oe    <= ~rd_byte[7];
                            state_reg <= ST_READ;
                        end else begin
                            sda_oe    <= 1'b0;
                            state_reg <= ST_SUB;
                        end
                    end
                end
                ST_ACK_SUB, ST_ACK_WR: begin
                    if (scl_fall) begin
                        sda_oe      <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_end) begin
                        sda_oe    <= 1'b0;
                        ptr_reg   <= next_sub(ptr_reg);
                        state_reg <= ST_READ_ACK;
                    end else if (scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe <= ~tx_reg[6];
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        nack_reg <= sda_lvl;
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (nack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            tx_reg    <= rd_byte;
                            sda_oe    <= ~rd_byte[7];
                            state_reg <= ST_READ;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    // Status is computed live, so writes to it only land in a shadow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                reg_file[i] <= REG_RESET;
            end
        end else if (wr_en) begin
            reg_file[ptr_reg] <= shift_reg;
        end
    end

    // ------------------------------------------------------------
    // Reference clock control
    // ------------------------------------------------------------
    ref_lock_ctrl u_ref (
        .clk             (clk),
        .rst_n           (rst_n),
        .ref_ctrl        (reg_file[SUB_REF_CTRL]),
        .acq_ctrl        (reg_file[SUB_ACQ_CTRL]),
        .lock_lost_in    (lock_lost_in),
        .ref_lock_mode   (ref_lock_mode),
        .fine_measure_en (fine_measure_en),
        .ref_range       (ref_range),
        .ref_ratio       (ref_ratio),
        .acquire_start   (acquire_start),
        .acquire_request (acquire_request),
        .locked          (locked)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence quiet;
        !start_det && !stop_det;
    endsequence

    sequence addr_done;
        quiet ##0 (state_reg == ST_ADDR) && byte_end;
    endsequence

    sequence sub_done;
        quiet ##0 (state_reg == ST_SUB) && byte_end;
    endsequence

    sequence ack_slot_end;
        quiet ##0 (state_reg == ST_ACK_SUB || state_reg == ST_ACK_WR) && scl_fall;
    endsequence

    sequence read_byte_end;
        quiet ##0 (state_reg == ST_READ) && byte_end;
    endsequence

    sequence read_ack_end;
        quiet ##0 (state_reg == ST_READ_ACK) && scl_fall;
    endsequence

    addr_ack_a: assert property (addr_done ##0 own_match |=> sda_oe && state_reg == ST_ACK_ADDR)
        else $error("own address not acknowledged");
    addr_miss_a: assert property (addr_done ##0 !own_match |=> !sda_oe && state_reg == ST_IDLE)
        else $error("foreign address not released");
    start_addr_a: assert property (start_det && !stop_det |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
        else $error("start not taken");
    stop_idle_a: assert property (stop_det |=> state_reg == ST_IDLE && !sda_oe)
        else $error("stop did not idle");
    bad_sub_a: assert property (sub_done ##0 (shift_reg >= SUB_COUNT) |=> state_reg == ST_IDLE && !sda_oe)
        else $error("invalid subaddress acknowledged");
    wr_ptr_a: assert property (wr_en |=> ptr_reg == next_sub($past(ptr_reg)) && reg_file[$past(ptr_reg)] == $past(shift_reg))
        else $error("write pointer or data wrong");
    rd_top_a: assert property (quiet ##0 state_reg == ST_READ && byte_end && ptr_reg == SUB_TOP |=> ptr_reg == SUB_TOP)
        else $error("read pointer left top register");
    oe_when_a: assert property (quiet ##0 $changed(sda_oe) && $past(!start_det && !stop_det) |-> $past(scl_fall))
        else $error("data line changed outside low clock");

    // ------------------------------------------------------------
    // Acknowledge slot and read path
    // ------------------------------------------------------------
    // Holding the ack past its slot would clash with the master's next bit
    ack_free_a: assert property (ack_slot_end |=> !sda_oe && state_reg == ST_WRITE)
        else $error("acknowledge held past its slot");
    sub_take_a: assert property (sub_done ##0 (shift_reg < SUB_COUNT)
        |=> sda_oe && ptr_reg == $past(shift_reg[2:0]))
        else $error("subaddress not taken");
    dir_latch_a: assert property (addr_done |=> rw_reg == $past(shift_reg[0]))
        else $error("direction bit not latched");
    msb_shift_a: assert property (quiet ##0 (state_reg == ST_ADDR) && scl_rise
        |=> shift_reg == {$past(shift_reg[6:0]), $past(sda_lvl)})
        else $error("bit not shifted in at lsb");
    rd_first_a: assert property (quiet ##0 (state_reg == ST_ACK_ADDR) && rw_reg && scl_fall
        |=> state_reg == ST_READ && sda_oe == !$past(rd_byte[7]))
        else $error("first read bit wrong");
    rd_release_a: assert property (read_byte_end |=> !sda_oe && state_reg == ST_READ_ACK)
        else $error("data line held in master ack slot");
    rd_next_a: assert property (read_ack_end ##0 !nack_reg
        |=> state_reg == ST_READ && tx_reg == $past(rd_byte))
        else $error("next read byte not loaded");
    rd_stop_a: assert property (read_ack_end ##0 nack_reg |=> state_reg == ST_IDLE && !sda_oe)
        else $error("read not ended on no acknowledge");
    idle_free_a: assert property (state_reg == ST_IDLE |-> !sda_oe)
        else $error("data line pulled while idle");
    wr_top_a: assert property (wr_en && ptr_reg == SUB_TOP |=> ptr_reg == SUB_TOP)
        else $error("write pointer left top register");

endmodule

// ---- src/cdr_pkg.sv ----
package cdr_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [2:0] SUB_REF_CTRL    = 3'h0;
    localparam logic [2:0] SUB_ACQ_CTRL    = 3'h1;
    localparam logic [2:0] SUB_STATUS      = 3'h2;
    localparam logic [2:0] SUB_TOP         = 3'h7;
    localparam logic [7:0] SUB_COUNT       = 8'h08;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam int         LTR_BIT         = 0;
    localparam int         FINE_BIT        = 1;
    localparam int         RATIO_LSB       = 2;
    localparam int         RANGE_LSB       = 6;
    localparam int         ACQ_RESTART_BIT = 5;
    localparam int         STS_ACQ_BIT     = 0;
    localparam int         STS_LOCKED_BIT  = 1;

    // ------------------------------------------------------------
    // Serial port constants
    // ------------------------------------------------------------
    localparam logic       ADDR_MSB_VALUE  = 1'b1;
    localparam logic [4:0] ADDR_LOW_VALUE  = 5'h00;
    localparam logic [3:0] BYTE_BITS       = 4'h8;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_SUB      = 9'h008,
        ST_ACK_SUB  = 9'h010,
        ST_WRITE    = 9'h020,
        ST_ACK_WR   = 9'h040,
        ST_READ     = 9'h080,
        ST_READ_ACK = 9'h100
    } i2c_state_t;

    typedef enum logic [2:0] {
        LK_FREE   = 3'h1,
        LK_ACQ    = 3'h2,
        LK_LOCKED = 3'h4
    } lock_state_t;

    // Pointer advance that sticks at the top register
    function automatic logic [2:0] next_sub(input logic [2:0] p);
        return (p == SUB_TOP) ? p : p + 3'h1;
    endfunction

endpackage

// ---- src/i2c_line_sync.sv ----
module i2c_line_sync
    import cdr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic addr_pin,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det,
    output logic      sda_lvl,
    output logic      addr_sel
);

    // ------------------------------------------------------------
    // Two-stage synchronisers, third stage for edges
    // ------------------------------------------------------------
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [1:0] last_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 3'h3;
            sync_reg <= 3'h3;
            last_reg <= 2'h3;
        end else begin
            meta_reg <= {addr_pin, sda_in, scl_in};
            sync_reg <= meta_reg;
            last_reg <= sync_reg[1:0];
        end
    end

    // Bus idles high, so reset values fake no edge
    assign scl_rise  = sync_reg[0] & ~last_reg[0];
    assign scl_fall  = ~sync_reg[0] & last_reg[0];
    assign start_det = sync_reg[0] & last_reg[0] & last_reg[1] & ~sync_reg[1];
    assign stop_det  = sync_reg[0] & last_reg[0] & ~last_reg[1] & sync_reg[1];
    assign sda_lvl   = sync_reg[1];
    assign addr_sel  = sync_reg[2];

endmodule

// ---- src/ref_lock_ctrl.sv ----
module ref_lock_ctrl
    import cdr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] ref_ctrl,
    input  wire logic [7:0] acq_ctrl,
    input  wire logic       lock_lost_in,
    output logic            ref_lock_mode,
    output logic            fine_measure_en,
    output logic [1:0]      ref_range,
    output logic [3:0]      ref_ratio,
    output logic            acquire_start,
    output logic            acquire_request,
    output logic            locked
);

    lock_state_t lock_reg;
    logic        lost_meta_reg;
    logic        lost_sync_reg;
    logic        restart_last_reg;
    logic        ltr_last_reg;
    logic        restart_fall;
    logic        ltr_rise;
    logic        relock;

    // ------------------------------------------------------------
    // Mode fields
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_lock_mode   <= 1'b0;
            fine_measure_en <= 1'b0;
            ref_range       <= 2'h0;
            ref_ratio       <= 4'h0;
        end else begin
            ref_lock_mode   <= ref_ctrl[LTR_BIT];
            fine_measure_en <= ref_ctrl[FINE_BIT];
            ref_range       <= ref_ctrl[RANGE_LSB +: 2];
            ref_ratio       <= ref_ctrl[RATIO_LSB +: 4];
        end
    end

    // ------------------------------------------------------------
    // Acquisition triggers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lost_meta_reg    <= 1'b0;
            lost_sync_reg    <= 1'b0;
            restart_last_reg <= 1'b0;
            ltr_last_reg     <= 1'b0;
        end else begin
            lost_meta_reg    <= lock_lost_in;
            lost_sync_reg    <= lost_meta_reg;
            restart_last_reg <= acq_ctrl[ACQ_RESTART_BIT];
            ltr_last_reg     <= ref_ctrl[LTR_BIT];
        end
    end

    // Software restarts with a one then a zero on the restart bit
    assign restart_fall = restart_last_reg & ~acq_ctrl[ACQ_RESTART_BIT];
    assign ltr_rise     = ~ltr_last_reg & ref_ctrl[LTR_BIT];
    assign relock       = (lock_reg == LK_LOCKED) & lost_sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acquire_start <= 1'b0;
        end else begin
            acquire_start <= ref_ctrl[LTR_BIT] & (restart_fall | ltr_rise | relock);
        end
    end

    // ------------------------------------------------------------
    // Lock tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= LK_FREE;
        end else if (!ref_ctrl[LTR_BIT]) begin
            lock_reg <= LK_FREE;
        end else begin
            unique case (lock_reg)
                LK_FREE:   lock_reg <= LK_ACQ;
                LK_ACQ:    lock_reg <= lost_sync_reg ? LK_ACQ : LK_LOCKED;
                LK_LOCKED: lock_reg <= (restart_fall | relock) ? LK_ACQ : LK_LOCKED;
                default:   lock_reg <= LK_FREE;
            endcase
        end
    end

    assign acquire_request = (lock_reg == LK_ACQ);
    assign locked          = (lock_reg == LK_LOCKED);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ltr_follow_a: assert property (ref_ctrl[LTR_BIT] |=> ref_lock_mode)
        else $error("lock mode does not follow control bit");
    fine_follow_a: assert property ($rose(ref_ctrl[FINE_BIT]) |=> $rose(fine_measure_en))
        else $error("fine measure enable late");
    relock_go_a: assert property (relock && ref_ctrl[LTR_BIT] |=> acquire_request && acquire_start)
        else $error("no relock after loss of lock");

endmodule

// ---- tb/i2c_master_model.sv ----
module i2c_master_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Two-wire bus master on a pulled-up wire
    // ----------------------------------------
    // Link period 48 ns. The low phase is the longer one so that the device's
    // synchroniser delay settles its data before the clock rises again.
    localparam realtime LOW  = 28.0;
    localparam realtime HIGH = 20.0;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Data moves mid-low and is sampled just before the clock falls
    task automatic put_bit(input logic b, output logic seen);
        #(LOW / 2) sda_pull = ~b;
        #(LOW / 2) scl = 1'b1;
        #(HIGH - 1.0) seen = sda_line;
        #1.0 scl = 1'b0;
    endtask

    // Data falls while the clock is high; also serves as repeated start
    task automatic start_c();
        #(LOW / 2) sda_pull = 1'b0;
        #(LOW / 2) scl = 1'b1;
        #HIGH sda_pull = 1'b1;
        #HIGH scl = 1'b0;
    endtask

    // Data rises while the clock is high; the clock then stands still
    task automatic stop_c();
        #(LOW / 2) sda_pull = 1'b1;
        #(LOW / 2) scl = 1'b1;
        #HIGH sda_pull = 1'b0;
        #HIGH;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    // Wire released on the ninth pulse after the last wanted byte
    task automatic recv_byte(input logic ack, output logic [7:0] d, output logic ninth);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(~ack, ninth);
    endtask
endmodule

// ---- tb/tb_cdr_i2c_slave_reference_clock_in_ctrl.sv ----
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module tb_cdr_i2c_slave_reference_clock_in_ctrl
    import cdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;
    logic       rst_n;
    logic       pin;
    logic       lock_lost;
    logic       scl;
    logic       sda_pull;
    wire        sda_line;
    logic       sda_out;
    logic       sda_oe;
    logic       ref_lock_mode;
    logic       fine_measure_en;
    logic [1:0] ref_range;
    logic [3:0] ref_ratio;
    logic       acquire_start;
    logic       acquire_request;
    logic [7:0] wdat [0:7];
    logic [7:0] rdat [0:7];
    int         failures = 0;
    int         checks = 0;
    int         pulses = 0;

    // Open-drain wire with pull-up: low while any party pulls
    assign sda_line = ~((sda_oe & ~sda_out) | sda_pull);

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (acquire_start === 1'b1) begin
            pulses++;
        end
    end

    cdr_i2c_slave_reference_clock_in_ctrl uut (
        .clk                  (clk),
        .rst_n                (rst_n),
        .scl_in               (scl),
        .sda_in               (sda_line),
        .sda_out              (sda_out),
        .sda_oe               (sda_oe),
        .addr_bit5_select_pin (pin),
        .lock_lost_in         (lock_lost),
        .ref_lock_mode        (ref_lock_mode),
        .fine_measure_en      (fine_measure_en),
        .ref_range            (ref_range),
        .ref_ratio            (ref_ratio),
        .acquire_start        (acquire_start),
        .acquire_request      (acquire_request)
    );

    i2c_master_model m (
        .scl      (scl),
        .sda_pull (sda_pull),
        .sda_line (sda_line)
    );

    function automatic logic [6:0] dev_addr(input logic p);
        return {1'b1, p, 5'h00};
    endfunction

    task automatic finish_test();
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr_regs(input logic [7:0] sub, input int n);
        logic a;
        m.start_c();
        m.send_byte({dev_addr(pin), 1'b0}, a);
        m.send_byte(sub, a);
        `CHK(a, 1'b1)
        for (int i = 0; i < n; i++) begin
            m.send_byte(wdat[i], a);
            `CHK(a, 1'b1)
        end
        m.stop_c();
    endtask

    task automatic rd_regs(input logic [7:0] sub, input int n);
        logic a;
        logic ninth;
        m.start_c();
        m.send_byte({dev_addr(pin), 1'b0}, a);
        m.send_byte(sub, a);
        m.start_c();
        m.send_byte({dev_addr(pin), 1'b1}, a);
        `CHK(a, 1'b1)
        for (int i = 0; i < n; i++) begin
            m.recv_byte(i < n - 1, rdat[i], ninth);
        end
        `CHK(ninth, 1'b1)
        m.stop_c();
    endtask

    task automatic wait_req(input logic v);
        int n;
        n = 0;
        while (acquire_request !== v && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n == 500) begin
            failures++;
            finish_test();
        end else begin
            repeat (4) @(posedge clk);
            `CHK(acquire_request, v)
        end
    endtask

    initial begin
        logic       a;
        logic       b;
        logic [6:0] bad;
        logic [3:0] ratio;
        logic [1:0] mode;
        int         p0;
        void'($urandom(94604));
        rst_n = 1'b0;
        pin = 1'b0;
        lock_lost = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({ref_range, ref_ratio, fine_measure_en, ref_lock_mode}, 8'h00)
        // ----------------------------------------
        // Address match on both strap levels
        // ----------------------------------------
        for (int p = 0; p < 2; p++) begin
            pin <= p[0];
            repeat (4) @(posedge clk);
            m.start_c();
            m.send_byte({dev_addr(pin), 1'b0}, a);
            `CHK(a, 1'b1)
            m.stop_c();
            bad = (p == 0) ? 7'h20 : 7'(($urandom % 127) + 1);
            m.start_c();
            m.send_byte({dev_addr(pin) ^ bad, 1'b0}, a);
            `CHK(a, 1'b0)
            m.send_byte(8'h00, a);
            `CHK(a, 1'b0)
            m.stop_c();
        end
        // ----------------------------------------
        // Reference control fields, all range codes
        // ----------------------------------------
        for (int r = 0; r < 4; r++) begin
            ratio = (r == 0) ? 4'h0 : (r == 3) ? 4'h8 : 4'($urandom % 9);
            mode = 2'(r % 3); // Never both modes at once
            wdat[0] = {2'(r), ratio, mode};
            wr_regs(8'(SUB_REF_CTRL), 1);
            repeat (4) @(posedge clk);
            `CHK(ref_range, 2'(r))
            `CHK(ref_ratio, ratio)
            `CHK(ref_lock_mode, mode[LTR_BIT])
            `CHK(fine_measure_en, mode[FINE_BIT])
            rd_regs(8'(SUB_REF_CTRL), 1);
            `CHK(rdat[0], wdat[0])
        end
        // Burst past the top register, then read back beyond it
        for (int i = 0; i < 6; i++) wdat[i] = 8'($urandom);
        wr_regs(8'h03, 6);
        rd_regs(8'h03, 7);
        for (int i = 0; i < 7; i++) begin
            `CHK(rdat[i], wdat[(i < 4) ? i : 5])
        end
        // Subaddresses beyond the map
        for (int k = 0; k < 2; k++) begin
            m.start_c();
            m.send_byte({dev_addr(pin), 1'b0}, a);
            m.send_byte((k == 0) ? 8'h08 : 8'(8 + $urandom % 248), a);
            `CHK(a, 1'b0)
            m.send_byte(8'hff, a);
            `CHK(a, 1'b0)
            m.stop_c();
        end
        // Stray start in mid-byte must abandon the write
        m.start_c();
        m.send_byte({dev_addr(pin), 1'b0}, a);
        m.send_byte(8'h04, a);
        for (int i = 0; i < 4; i++) m.put_bit(~wdat[1][7 - i], b);
        m.start_c();
        m.send_byte({dev_addr(pin), 1'b0}, a);
        `CHK(a, 1'b1)
        m.stop_c();
        rd_regs(8'h04, 1);
        `CHK(rdat[0], wdat[1])
        // ----------------------------------------
        // Lock tracking and acquisition restarts
        // ----------------------------------------
        p0 = pulses;
        wdat[0] = 8'h01;
        wr_regs(8'(SUB_REF_CTRL), 1);
        wait_req(1'b0);
        `CHK(pulses, p0 + 1)
        rd_regs(8'(SUB_STATUS), 1);
        `CHK(rdat[0], 8'(1 << STS_LOCKED_BIT))
        lock_lost <= 1'b1;
        wait_req(1'b1);
        `CHK(pulses, p0 + 2)
        rd_regs(8'(SUB_STATUS), 1);
        `CHK(rdat[0], 8'(1 << STS_ACQ_BIT))
        lock_lost <= 1'b0;
        wait_req(1'b0);
        // Restart is a one then a zero in the restart bit
        wdat[0] = 8'(1 << ACQ_RESTART_BIT);
        wr_regs(8'(SUB_ACQ_CTRL), 1);
        wdat[0] = 8'h00;
        wr_regs(8'(SUB_ACQ_CTRL), 1);
        repeat (4) @(posedge clk);
        `CHK(pulses, p0 + 3)
        finish_test();
    end
endmodule
